// file: src/dqtx_pkg.sv
/*
 * Constants of the DQPSK transmit port control block: register map,
 * field positions, reset values and master-clock tick counts.
 * Assumes a 32-bit classic Wishbone slave with byte addresses.
 */
package dqtx_pkg;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_STATUS   = 8'h04;
	localparam logic [7:0] REG_SYMBOL   = 8'h08;
	localparam logic [7:0] REG_DAC      = 8'h0c;
	localparam logic [7:0] REG_IRQ_STAT = 8'h10;
	localparam logic [7:0] REG_IRQ_CLR  = 8'h14;
	localparam logic [7:0] REG_IRQ_EN   = 8'h18;

	// Control fields and reset values
	localparam int          CTRL_FORCE_SLEEP = 0;
	localparam int          CTRL_BURST_MASK  = 1;
	localparam logic [1:0]  CTRL_RESET       = 2'h0;
	localparam int          IRQ_BITS         = 5;
	localparam logic [4:0]  IRQ_RESET        = 5'h00;
	localparam int          IRQ_READY        = 0;
	localparam int          IRQ_BURST_START  = 1;
	localparam int          IRQ_BURST_END    = 2;
	localparam int          IRQ_SYMBOL       = 3;
	localparam int          IRQ_DAC_WORD     = 4;

	// Mode select encodings {a, b}
	localparam logic [1:0]  MODE_DIGITAL = 2'h0;
	localparam logic [1:0]  MODE_ANALOG  = 2'h2;
	localparam logic [1:0]  MODE_FTEST   = 2'h1;

	// Counts in master-clock ticks, bit-clock cycles, bits and synchroniser stages
	localparam int          CAL_TICKS_DEFAULT   = 4097;
	localparam logic [2:0]  LEAD_TICKS          = 3'h3;
	localparam logic [5:0]  BITCLK_HALF_TICKS   = 6'h20;
	localparam logic [3:0]  TAIL_CYCLES         = 4'h8;
	localparam logic [4:0]  WORD_BITS           = 5'h10;
	localparam int          DAC_BITS            = 10;
	localparam int          BURST_DELAY_DEFAULT = 16;
	localparam int          SYNC_STAGES         = 2;

	typedef enum {ST_IDLE, ST_LEAD, ST_RUN, ST_TAIL} dqtx_state_t;
endpackage : dqtx_pkg

// file: src/dqtx_delay_line.sv
/*
 * Tick-enabled delay line carrying the burst request to the burst-out pin.
 * Assumes shiftEn is a one-cycle enable on clk.
 */
`timescale 1ns/1ps
module dqtx_delay_line #(
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// Stream
	input  wire logic shiftEn,
	input  wire logic dataIn,
	output logic      dataOut
);
	import dqtx_pkg::*;

	logic [DEPTH-1:0] taps_q;

	// Output is the last tap, so it is a flop
	assign dataOut = taps_q[DEPTH-1];

	always_ff @(posedge clk) begin
		if (reset) begin
			taps_q <= '0;
		end else if (shiftEn) begin
			taps_q <= {taps_q[DEPTH-2:0], dataIn};
		end
	end

	property p_delay_hold;
		@(posedge clk) disable iff (reset)
		!shiftEn |=> $stable(dataOut);
	endproperty
	a_delay_hold: assert property (p_delay_hold) else $error("delay moved without tick");
endmodule : dqtx_delay_line

// file: src/dqtx_port_control.sv
/*
 * Transmit port control: mode decode, bit clock, serial capture, burst
 * ramp control, calibration sequencing, analog bypass words, Wishbone regs.
 * Assumes master clock, pins and mode inputs are asynchronous to clk.
 */
// Operation
// - Digital mode drives bit clock out
// - Analog mode: pin is frame strobe input
// - Capture serial bit on bit clock fall
// - Analog mode: in-phase bits to DAC
// - Analog mode: quadrature bits to DAC
// - Burst high ramps up, low ramps down
// - Burst out is delayed burst request
// - Wake low puts section to sleep
// - Wake high starts offset self-calibration
// - Ready rises when calibration finishes
// - Two mode inputs decode three modes
// - Both mode inputs low: digital mode
// - Wake sampled on master clock rise
// - Eight more bit clocks after burst falls
`timescale 1ns/1ps
module dqtx_port_control #(
	parameter int CAL_TICKS   = dqtx_pkg::CAL_TICKS_DEFAULT,
	parameter int BURST_DELAY = dqtx_pkg::BURST_DELAY_DEFAULT
) (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         reset,
	// Wishbone slave
	input  wire logic                         cyc_i,
	input  wire logic                         stb_i,
	input  wire logic                         we_i,
	input  wire logic [7:0]                   adr_i,
	input  wire logic [3:0]                   sel_i,
	input  wire logic [31:0]                  dat_i,
	output logic      [31:0]                  dat_o,
	output logic                              ack_o,
	output logic                              irqOut,
	// Port pins
	input  wire logic                         masterClkIn,
	input  wire logic                         txBitClockIn,
	output logic                              txBitClockOut,
	output logic                              txBitClockOeN,
	input  wire logic                         txSerialBitsIn,
	input  wire logic                         burstRequestIn,
	output logic                              burstDelayedOut,
	input  wire logic                         modeSelectA,
	input  wire logic                         modeSelectB,
	input  wire logic                         wakeIn,
	output logic                              readyOut,
	// Converter side
	output logic      [dqtx_pkg::DAC_BITS-1:0] inphaseDacOut,
	output logic      [dqtx_pkg::DAC_BITS-1:0] quadratureDacOut,
	output logic                              sleepOut
);
	import dqtx_pkg::*;

	// Synchronisers
	logic [6:0] syncRaw;
	logic [6:0] sync1_q;
	logic [6:0] sync2_q;
	assign syncRaw = {masterClkIn, txBitClockIn, txSerialBitsIn, burstRequestIn,
		modeSelectA, modeSelectB, wakeIn};
	genvar gi;
	generate
		for (gi = 0; gi < 7; gi++) begin : g_sync
			always_ff @(posedge clk) begin
				if (reset) begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
				end else begin
					sync1_q[gi] <= syncRaw[gi];
					sync2_q[gi] <= sync1_q[gi];
				end
			end
		end
	endgenerate

	wire       mclkS      = sync2_q[6];
	wire       frameS     = sync2_q[5];
	wire       serialS    = sync2_q[4];
	wire       burstS     = sync2_q[3];
	wire [1:0] modeS      = sync2_q[2:1];
	wire       wakeS      = sync2_q[0];
	wire       inphaseS   = serialS;
	wire       quadS      = burstS;

	logic mclkPrev_q;
	always_ff @(posedge clk) begin
		if (reset) begin
			mclkPrev_q <= 1'b0;
		end else begin
			mclkPrev_q <= mclkS;
		end
	end
	// Master clock rate is the controller's duty; only its edges matter here
	wire mclkTick = mclkS & ~mclkPrev_q;

	// Mode decode; test and reserved codes leave the port idle
	wire modeDigital = (modeS == MODE_DIGITAL);
	wire modeAnalog  = (modeS == MODE_ANALOG);

	// Control registers
	logic [1:0]          ctrl_q;
	logic [IRQ_BITS-1:0] irqStat_q;
	logic [IRQ_BITS-1:0] irqEn_q;
	logic                ack_q;

	// Sleep and calibration
	logic        wakeSeen_q;
	logic        sleep_q;
	logic        calDone_q;
	logic [12:0] calCount_q;
	wire         wakeReq  = wakeS & ~ctrl_q[CTRL_FORCE_SLEEP];
	wire         calLast  = (calCount_q == 13'(CAL_TICKS - 1));

	always_ff @(posedge clk) begin
		if (reset) begin
			wakeSeen_q <= 1'b0;
		end else if (mclkTick) begin
			wakeSeen_q <= wakeReq;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			sleep_q    <= 1'b1;
			calDone_q  <= 1'b0;
			calCount_q <= '0;
		end else if (!wakeSeen_q) begin
			sleep_q    <= 1'b1;
			calDone_q  <= 1'b0;
			calCount_q <= '0;
		end else begin
			sleep_q <= 1'b0;
			if (mclkTick && !calDone_q) begin
				calCount_q <= calCount_q + 13'h0001;
				calDone_q  <= calLast;
			end
		end
	end
	assign sleepOut = sleep_q;

	// Burst state machine and bit clock
	dqtx_state_t  state_q;
	logic [2:0]   lead_q;
	logic [5:0]   phase_q;
	logic [3:0]   tail_q;
	logic         bitClk_q;
	logic         rampUp_q;
	logic         rampDown_q;
	logic         half_q;
	logic         firstBit_q;
	logic [1:0]   dibit_q;
	logic [7:0]   symCount_q;
	logic         burstPrev_q;

	wire active   = modeDigital & calDone_q;
	// Burst accepted only while ready, on a rising request, so a request raised before ready is dropped
	wire accept   = active & mclkTick & burstS & ~burstPrev_q & readyOut
		& ~ctrl_q[CTRL_BURST_MASK] & (state_q == ST_IDLE);
	wire running  = (state_q == ST_RUN) | (state_q == ST_TAIL);
	wire fallTick = running & mclkTick & (phase_q == BITCLK_HALF_TICKS - 6'h01);
	wire wrapTick = running & mclkTick & (phase_q == 6'h3f);
	// The period in flight when the request drops is not one of the eight
	wire tailEnd  = (state_q == ST_TAIL) & wrapTick & (tail_q == TAIL_CYCLES);
	wire symDone  = fallTick & half_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			burstPrev_q <= 1'b0;
		end else if (mclkTick) begin
			burstPrev_q <= burstS;
		end
	end

	always_ff @(posedge clk) begin
		if (reset || !active) begin
			state_q    <= ST_IDLE;
			lead_q     <= '0;
			phase_q    <= '0;
			tail_q     <= '0;
			rampUp_q   <= 1'b0;
			rampDown_q <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (accept) begin
						state_q  <= ST_LEAD;
						lead_q   <= '0;
						rampUp_q <= 1'b1;
					end
				end
				ST_LEAD: begin
					if (mclkTick) begin
						lead_q <= lead_q + 3'h1;
						if (lead_q == LEAD_TICKS - 3'h1) begin
							state_q <= ST_RUN;
							phase_q <= '0;
						end
					end
				end
				ST_RUN: begin
					if (mclkTick) begin
						phase_q <= phase_q + 6'h01;
						if (!burstS) begin
							state_q    <= ST_TAIL;
							tail_q     <= '0;
							rampUp_q   <= 1'b0;
							rampDown_q <= 1'b1;
						end
					end
				end
				ST_TAIL: begin
					if (mclkTick) begin
						phase_q <= phase_q + 6'h01;
					end
					if (tailEnd) begin
						state_q    <= ST_IDLE;
						rampDown_q <= 1'b0;
					end else if (wrapTick) begin
						tail_q <= tail_q + 4'h1;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Bit clock is high in the first half of each 64-tick period
	always_ff @(posedge clk) begin
		if (reset) begin
			bitClk_q <= 1'b0;
		end else begin
			bitClk_q <= running & (phase_q < BITCLK_HALF_TICKS) & ~tailEnd;
		end
	end
	assign txBitClockOut = bitClk_q;
	assign txBitClockOeN = ~modeDigital;

	// Serial capture at each falling edge, paired into dibits
	always_ff @(posedge clk) begin
		if (reset || accept) begin
			half_q     <= 1'b0;
			firstBit_q <= 1'b0;
			dibit_q    <= '0;
			symCount_q <= '0;
		end else if (fallTick) begin
			half_q <= ~half_q;
			if (!half_q) begin
				firstBit_q <= serialS;
			end else begin
				dibit_q    <= {firstBit_q, serialS};
				symCount_q <= symCount_q + 8'h01;
			end
		end
	end

	// Analog bypass: frame marks the first bit of a 16-bit word
	logic [DAC_BITS-1:0] iShift_q;
	logic [DAC_BITS-1:0] qShift_q;
	logic [4:0]          bitCnt_q;
	logic [DAC_BITS-1:0] iDac_q;
	logic [DAC_BITS-1:0] qDac_q;
	wire                 anaTick  = modeAnalog & mclkTick & ~sleep_q;
	// Bits outside a framed word are ignored, so no stray word reaches the DACs
	wire  [4:0]          cntNext  = frameS ? 5'h01 :
		(bitCnt_q == 5'h00) ? 5'h00 : bitCnt_q + 5'h01;
	wire                 wordDone = anaTick & (cntNext == WORD_BITS);
	wire  [DAC_BITS-1:0] iNext    = {iShift_q[DAC_BITS-2:0], inphaseS};
	wire  [DAC_BITS-1:0] qNext    = {qShift_q[DAC_BITS-2:0], quadS};

	always_ff @(posedge clk) begin
		if (reset) begin
			iShift_q <= '0;
			qShift_q <= '0;
			bitCnt_q <= '0;
		end else if (anaTick) begin
			iShift_q <= iNext;
			qShift_q <= qNext;
			bitCnt_q <= wordDone ? 5'h00 : cntNext;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			iDac_q <= '0;
			qDac_q <= '0;
		end else if (wordDone) begin
			iDac_q <= iNext;
			qDac_q <= qNext;
		end
	end
	assign inphaseDacOut    = iDac_q;
	assign quadratureDacOut = qDac_q;

	// Ready is held off during a burst and its tail
	logic ready_q;
	always_ff @(posedge clk) begin
		if (reset) begin
			ready_q <= 1'b0;
		end else begin
			ready_q <= calDone_q & (state_q == ST_IDLE) & ~accept;
		end
	end
	assign readyOut = ready_q;

	// Burst out follows the request through the pipeline delay
	dqtx_delay_line #(
		.DEPTH (BURST_DELAY)
	) u_burst_delay (
		.clk     (clk),
		.reset   (reset),
		.shiftEn (mclkTick),
		.dataIn  (burstS & modeDigital),
		.dataOut (burstDelayedOut)
	);

	// Interrupt events; a set in the clearing cycle wins
	wire [IRQ_BITS-1:0] irqEvent = {wordDone, symDone, tailEnd, accept,
		calDone_q & ~ready_q & (state_q == ST_IDLE) & ~accept};

	// Wishbone decode
	wire req    = cyc_i & stb_i & ~ack_q;
	wire wrLow  = req & we_i & sel_i[0];
	wire wrCtrl = wrLow & (adr_i == REG_CTRL);
	wire wrClr  = wrLow & (adr_i == REG_IRQ_CLR);
	wire wrEn   = wrLow & (adr_i == REG_IRQ_EN);
	wire [31:0] statusWord = {23'h000000, burstDelayedOut, running, rampDown_q,
		rampUp_q, ~sleep_q & ~calDone_q, sleep_q, ready_q, modeS};
	wire [31:0] readMux =
		(adr_i == REG_CTRL)     ? {30'h00000000, ctrl_q} :
		(adr_i == REG_STATUS)   ? statusWord :
		(adr_i == REG_SYMBOL)   ? {16'h0000, symCount_q, 6'h00, dibit_q} :
		(adr_i == REG_DAC)      ? {6'h00, qDac_q, 6'h00, iDac_q} :
		(adr_i == REG_IRQ_STAT) ? {27'h0000000, irqStat_q} :
		(adr_i == REG_IRQ_EN)   ? {27'h0000000, irqEn_q} : 32'h00000000;

	always_ff @(posedge clk) begin
		if (reset) begin
			ack_q <= 1'b0;
			dat_o <= '0;
		end else begin
			ack_q <= req;
			dat_o <= (req && !we_i) ? readMux : 32'h00000000;
		end
	end
	assign ack_o = ack_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_q    <= CTRL_RESET;
			irqEn_q   <= IRQ_RESET;
			irqStat_q <= IRQ_RESET;
		end else begin
			if (wrCtrl) begin
				ctrl_q <= dat_i[1:0];
			end
			if (wrEn) begin
				irqEn_q <= dat_i[IRQ_BITS-1:0];
			end
			irqStat_q <= (irqStat_q & ~(wrClr ? dat_i[IRQ_BITS-1:0] : IRQ_RESET)) | irqEvent;
		end
	end
	assign irqOut = |(irqStat_q & irqEn_q);

	// Checks
	sequence s_lead;
		(state_q == ST_LEAD) && rampUp_q;
	endsequence
	sequence s_stop;
		(state_q == ST_IDLE) ##1 !bitClk_q;
	endsequence
	sequence s_capture;
		$changed(half_q) ##1 $fell(bitClk_q);
	endsequence

	// An input pin must never see the bit clock toggling behind it
	property p_pin_dir;
		@(posedge clk) disable iff (reset)
		(txBitClockOeN == (modeS != MODE_DIGITAL)) and (txBitClockOeN |-> ##2 !bitClk_q);
	endproperty
	a_pin_dir: assert property (p_pin_dir) else $error("bit clock pin direction wrong");

	property p_fall_capture;
		@(posedge clk) disable iff (reset) fallTick |=> s_capture;
	endproperty
	a_fall_capture: assert property (p_fall_capture) else $error("no capture at fall");

	property p_analog_load;
		@(posedge clk) disable iff (reset) wordDone |=> iDac_q == $past(iNext) && qDac_q == $past(qNext);
	endproperty
	a_analog_load: assert property (p_analog_load) else $error("DAC word not loaded");

	property p_ramp_start;
		@(posedge clk) disable iff (reset) accept |=> s_lead;
	endproperty
	a_ramp_start: assert property (p_ramp_start) else $error("ramp up did not start");

	property p_sleep_not_ready;
		@(posedge clk) disable iff (reset) sleep_q |=> !calDone_q ##1 !ready_q;
	endproperty
	a_sleep_not_ready: assert property (p_sleep_not_ready) else $error("ready while asleep");

	property p_cal_done;
		@(posedge clk) disable iff (reset)
		mclkTick && calLast && wakeSeen_q && !calDone_q |=> calDone_q ##1 (ready_q || state_q != ST_IDLE);
	endproperty
	a_cal_done: assert property (p_cal_done) else $error("ready late after calibration");

	property p_wake_tick;
		@(posedge clk) disable iff (reset) $changed(wakeSeen_q) |-> $past(mclkTick);
	endproperty
	a_wake_tick: assert property (p_wake_tick) else $error("wake sampled off tick");

	property p_mode;
		@(posedge clk) disable iff (reset) !(modeDigital && modeAnalog) && (modeDigital == (modeS == 2'h0));
	endproperty
	a_mode: assert property (p_mode) else $error("mode decode wrong");

	property p_accept_ready;
		@(posedge clk) disable iff (reset) accept |-> ready_q;
	endproperty
	a_accept_ready: assert property (p_accept_ready) else $error("burst taken without ready");

	property p_tail_end;
		@(posedge clk) disable iff (reset) tailEnd |=> s_stop;
	endproperty
	a_tail_end: assert property (p_tail_end) else $error("bit clock ran past tail");
endmodule : dqtx_port_control

// file: testbench/dqtx_ctrl_model.sv
/*
 * Controller model for the far side of the transmit port. It makes the master
 * clock and the serial bits, the burst request and the analog-mode words.
 * Assumes the bench resolves the shared bit-clock/frame pin and feeds it back.
 */
`timescale 1ns/1ps
module dqtx_ctrl_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Bench commands
	input  wire logic        analogMode,
	input  wire logic        burstCmd,
	input  wire logic [15:0] bitPattern,
	input  wire logic        wordGo,
	input  wire logic [15:0] iWord,
	input  wire logic [15:0] qWord,
	// Port pins
	input  wire logic        bitClockPin,
	output logic             masterClk,
	output logic             serialBit,
	output logic             burstPin,
	output logic             framePin,
	output logic             wordBusy
);
	logic [2:0]  phase;
	logic [15:0] txBits;
	logic [15:0] iShift;
	logic [15:0] qShift;
	logic [4:0]  bitIdx;
	logic        pinPrev;
	logic        burstLvl;
	logic        iBit;
	logic        qBit;

	// Pins are shared between modes
	assign serialBit = analogMode ? iBit : txBits[15];
	assign burstPin  = analogMode ? qBit : burstLvl;

	always_ff @(posedge clk) begin
		if (reset) begin
			phase     <= 3'h0;
			masterClk <= 1'b0;
			burstLvl  <= 1'b0;
			framePin  <= 1'b0;
			wordBusy  <= 1'b0;
			pinPrev   <= 1'b0;
			txBits    <= 16'h0000;
			iBit      <= 1'b0;
			qBit      <= 1'b0;
		end else begin
			phase   <= phase + 3'h1;
			pinPrev <= bitClockPin;
			if (phase == 3'h0) begin
				masterClk <= 1'b1; // scaled: eight clk per master period
			end
			if (pinPrev && !bitClockPin) begin
				txBits <= {txBits[14:0], txBits[15]}; // tail bits too
			end
			if (wordGo && !wordBusy) begin
				wordBusy <= 1'b1;
				bitIdx   <= 5'h00;
				iShift   <= iWord;
				qShift   <= qWord;
			end
			// Data moves on the fall, half a period clear of the sampling rise
			if (phase == 3'h4) begin
				masterClk <= 1'b0;
				burstLvl  <= burstCmd;
				if (burstCmd && !burstLvl) begin
					txBits <= bitPattern;
				end
				if (wordBusy && bitIdx == 5'h10) begin
					wordBusy <= 1'b0;
					framePin <= 1'b0;
					iBit     <= ~iBit; // Released lines show no stale value
					qBit     <= ~qBit;
				end else if (wordBusy) begin
					framePin <= (bitIdx == 5'h00);
					iBit     <= iShift[15];
					qBit     <= qShift[15];
					iShift   <= {iShift[14:0], 1'b0};
					qShift   <= {qShift[14:0], 1'b0};
					bitIdx   <= bitIdx + 5'h01;
				end
			end
		end
	end
endmodule : dqtx_ctrl_model

// file: testbench/testbench.sv
/*
 * Self-checking bench for the transmit port control block.
 * Assumes the controller model above and a pull-free shared pin.
 */
`timescale 1ns/1ps
module testbench;
	import dqtx_pkg::*;
	localparam int CAL  = 20;
	localparam int TICK = 8;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'hf;
	logic [31:0] datW = 32'h0;
	logic [31:0] datR;
	logic        ack, irqOut, mClk, bclkOut, txBitClockOeN, serBit, burstPin, frameDrv;
	logic        burstDelayedOut, readyOut, sleepOut, wordBusy;
	logic        modeA = 1'b0;
	logic        modeB = 1'b0;
	logic        wake = 1'b0;
	logic        burstCmd = 1'b0;
	logic        wordGo = 1'b0;
	logic [15:0] bitPattern = 16'h0000;
	logic [9:0]  iDac, qDac;
	int          err_total = 0;
	int          tests_run = 0;
	// Device drives the pin while its enable is low
	wire         pinLevel = txBitClockOeN ? frameDrv : bclkOut;

	always #10 clk = ~clk;

	dqtx_port_control #(.CAL_TICKS(CAL), .BURST_DELAY(16)) dut (
		.clk(clk), .reset(reset), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(sel), .dat_i(datW), .dat_o(datR), .ack_o(ack), .irqOut(irqOut),
		.masterClkIn(mClk), .txBitClockIn(pinLevel), .txBitClockOut(bclkOut),
		.txBitClockOeN(txBitClockOeN), .txSerialBitsIn(serBit), .burstRequestIn(burstPin),
		.burstDelayedOut(burstDelayedOut), .modeSelectA(modeA), .modeSelectB(modeB),
		.wakeIn(wake), .readyOut(readyOut), .inphaseDacOut(iDac), .quadratureDacOut(qDac),
		.sleepOut(sleepOut));

	dqtx_ctrl_model partner (
		.clk(clk), .reset(reset), .analogMode(modeA), .burstCmd(burstCmd),
		.bitPattern(bitPattern), .wordGo(wordGo), .iWord(16'hf2c5), .qWord(16'h0d3a),
		.bitClockPin(pinLevel), .masterClk(mClk), .serialBit(serBit), .burstPin(burstPin),
		.framePin(frameDrv), .wordBusy(wordBusy));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic report_and_stop;
		$display("Checks run %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop

	// Classic cycle: hold everything until ack is sampled, then one idle cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q);
		int n;
		@(posedge clk);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		datW <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) begin
			err_total++;
			$display("MISMATCH bus ack expected 1 seen %b", ack);
		end
		q = datR;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		wb(1'b0, a, 32'h0, q);
	endtask : rd

	task automatic wait_bclk(input logic v, output int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (bclkOut !== v && n < 1200);
		check("bit clock edge", bclkOut, v);
	endtask : wait_bclk

	task automatic t_regs;
		logic [31:0] q;
		rd(REG_STATUS, q);
		check("status reset", q, 32'h8);
		check("pin drive", txBitClockOeN, 1'b0);
		rd(8'h1c, q);
		check("unmapped", q, 32'h0);
		wr(REG_IRQ_EN, 32'h1f);
		rd(REG_IRQ_EN, q);
		check("irq enable", q, 32'h1f);
		wr(REG_STATUS, 32'hff);
		rd(REG_STATUS, q);
		check("status ro", q, 32'h8);
	endtask : t_regs

	task automatic t_refuse;
		burstCmd <= 1'b1;
		repeat (40 * TICK) @(posedge clk);
		check("early burst", bclkOut, 1'b0);
		burstCmd <= 1'b0;
		repeat (4 * TICK) @(posedge clk);
	endtask : t_refuse

	task automatic t_wake;
		int n;
		logic [31:0] q;
		wake <= 1'b1;
		n = 0;
		while (readyOut !== 1'b1 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		check("cal time", n >= CAL * TICK && n <= (CAL + 4) * TICK, 1'b1);
		check("awake", sleepOut, 1'b0);
		check("irq ready", irqOut, 1'b1);
		rd(REG_IRQ_STAT, q);
		check("irq stat", q, 32'h1);
		wr(REG_IRQ_CLR, 32'h1);
		check("irq clear", irqOut, 1'b0);
	endtask : t_wake

	task automatic t_burst;
		int n;
		int rises;
		logic prev;
		logic [31:0] q;
		wr(REG_IRQ_EN, 32'h0);
		bitPattern <= 16'hb000;
		burstCmd   <= 1'b1;
		wait_bclk(1'b1, n);
		check("lead", n <= 8 * TICK, 1'b1);
		check("pin drive", txBitClockOeN, 1'b0);
		check("burst_delayed_out early", burstDelayedOut, 1'b0);
		wait_bclk(1'b0, n);
		check("bclk high", n, 32 * TICK);
		check("burst_delayed_out late", burstDelayedOut, 1'b1);
		wait_bclk(1'b1, n);
		check("bclk low", n, 32 * TICK);
		wait_bclk(1'b0, n);
		repeat (2) begin
			wait_bclk(1'b1, n);
			wait_bclk(1'b0, n);
		end
		rd(REG_SYMBOL, q);
		check("symbol", q, 32'h0203);
		burstCmd <= 1'b0;
		rises = 0;
		n = 0;
		prev = bclkOut;
		while (readyOut !== 1'b1 && n < 12 * 64 * TICK) begin
			@(posedge clk);
			n++;
			if (bclkOut === 1'b1 && prev === 1'b0) begin
				rises++;
			end
			prev = bclkOut;
		end
		check("tail clocks", rises, 8);
		check("burst_delayed_out off", burstDelayedOut, 1'b0);
		rd(REG_IRQ_STAT, q);
		check("burst irqs", q, 32'h0f);
		check("irq masked", irqOut, 1'b0);
		wr(REG_IRQ_EN, 32'h1f);
		check("irq unmasked", irqOut, 1'b1);
		wr(REG_IRQ_CLR, 32'h1f);
		check("irq cleared", irqOut, 1'b0);
	endtask : t_burst

	task automatic t_analog;
		int n;
		logic [31:0] q;
		modeA <= 1'b1;
		repeat (8) @(posedge clk);
		check("frame input", txBitClockOeN, 1'b1);
		rd(REG_STATUS, q);
		check("mode analog", q[1:0], 2'h2);
		wordGo <= 1'b1;
		@(posedge clk);
		wordGo <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wordBusy !== 1'b0 && n < 400);
		// Wait past where a second, unframed word would have landed
		repeat (20 * TICK) @(posedge clk);
		check("i dac", iDac, 10'h2c5);
		check("q dac", qDac, 10'h13a);
		rd(REG_DAC, q);
		check("dac reg", q, 32'h013a02c5);
		rd(REG_IRQ_STAT, q);
		check("word irq", q, 32'h10);
		check("burst_delayed_out quiet", burstDelayedOut, 1'b0);
		modeA <= 1'b0;
		modeB <= 1'b1;
		repeat (8) @(posedge clk);
		check("test mode pin", txBitClockOeN, 1'b1);
		rd(REG_STATUS, q);
		check("mode test", q[1:0], 2'h1);
		modeB <= 1'b0;
		repeat (8) @(posedge clk);
		check("digital pin", txBitClockOeN, 1'b0);
	endtask : t_analog

	task automatic t_sleep;
		logic [31:0] q;
		wr(REG_CTRL, 32'h1);
		repeat (4 * TICK) @(posedge clk);
		check("forced sleep", sleepOut, 1'b1);
		wr(REG_CTRL, 32'h0);
		wake <= 1'b0;
		repeat (4 * TICK) @(posedge clk);
		check("asleep", sleepOut, 1'b1);
		check("not ready", readyOut, 1'b0);
		rd(REG_STATUS, q);
		check("sleep bit", q[3], 1'b1);
	endtask : t_sleep

	initial begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		t_regs();
		t_refuse();
		t_wake();
		t_burst();
		t_analog();
		t_sleep();
		report_and_stop();
	end

	// Whole run needs under 20000 cycles
	initial begin
		#(60000 * 20);
		err_total++;
		report_and_stop();
	end
endmodule : testbench
